// ### ibsf_pkg.sv
// constants and types shared by the bus status flag block
// assumes one 250 MHz clock and a byte wide register port
package ibsf_pkg;

  // ==========================================================
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_EN = 4'h3;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h4;

  // ==========================================================
  // status register fields
  localparam int ST_DIR = 3;
  localparam int ST_ACK = 2;
  localparam int ST_START = 1;
  localparam int ST_STOP = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ==========================================================
  // control register fields
  localparam int CT_ENABLE = 0;
  localparam int CT_MASTER = 1;
  localparam int CT_START_GEN = 2;
  localparam int CT_WAIT_REL = 3;
  localparam int CT_COMM_SAVE = 4;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ==========================================================
  // interrupt fields
  localparam int IRQ_W = 3;
  localparam int IQ_START = 0;
  localparam int IQ_STOP = 1;
  localparam int IQ_ACK = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ==========================================================
  // serial clock counting
  localparam logic [3:0] CNT_IDLE = 4'h0;
  localparam logic [3:0] CNT_DIR_BIT = 4'h8;
  localparam logic [3:0] CNT_ACK_BIT = 4'h9;
  localparam logic [3:0] CNT_FIRST = 4'h1;

  typedef enum logic [1:0] {
    IBSF_PH_IDLE = 2'b00,
    IBSF_PH_ADDR = 2'b01,
    IBSF_PH_DATA = 2'b11
  } ibsf_phase_type;

endpackage

// ### ibsf_sync.sv
// two stage synchroniser, one lane per bit
// assumes inputs come from outside the mclk domain
`timescale 1ns/1ps
`default_nettype none
module ibsf_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // lanes
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // per bit flop pair
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_lane
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          meta_q[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### ibsf_cond.sv
// serial clock edges and start and stop conditions
// assumes synchronised line levels, idle high
`timescale 1ns/1ps
`default_nettype none
module ibsf_cond (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // synchronised lines
  input wire logic scl_s,
  input wire logic sda_s,
  // one cycle events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);

  typedef struct packed {
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } ibsf_cond_type;

  ibsf_cond_type s_q;
  ibsf_cond_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.scl = scl_s;
    s_d.sda = sda_s;
    s_d.rise = scl_s & ~s_q.scl;
    s_d.fall = ~scl_s & s_q.scl;
    // data edges while clock stays high
    s_d.start = scl_s & s_q.scl & s_q.sda & ~sda_s;
    s_d.stop = scl_s & s_q.scl & ~s_q.sda & sda_s;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      s_q <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
    else
      s_q <= s_d;
  end

  assign scl_rise = s_q.rise;
  assign scl_fall = s_q.fall;
  assign start_det = s_q.start;
  assign stop_det = s_q.stop;

endmodule
`default_nettype wire

// ### ibsf_top.sv
// bus status flags: direction, acknowledge, start and stop seen
// assumes pins sampled on mclk, register port on mclk, sync reset
//
// Functional notes
// R1: direction 0: receive, data line released
// R2: direction 1: drive latch after first ninth clock; here master start generation drives at once
// R3: master start generation sets direction
// R4: slave sets direction on first byte bit 1
// R5: master clears direction after sending bit 1
// R6: stop, save, disable, arbitration loss clear direction
// R7: wait release at ninth clock clears direction
// R8: acknowledge flag set on low ninth rise
// R9: acknowledge flag cleared on listed events
// R10: start flag set on start condition
// R11: start flag cleared after address byte
// R12: stop flag set on stop condition
// R13: stop flag cleared on next address clock
// R14: flags read only, reset to zero
// R15: software writes to flags ignored
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ibsf_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial lines
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // neighbouring logic
  input wire logic arbitration_lost_flag,
  input wire logic shift_out_bit,
  // flags and interrupt
  output logic transfer_direction_flag,
  output logic ack_seen_flag,
  output logic start_seen_flag,
  output logic stop_seen_flag,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic enable;
    logic master;
    logic en_prev;
    logic ald_prev;
    ibsf_pkg::ibsf_phase_type phase;
    logic [3:0] cnt;
    logic first_byte;
    logic drive_ok;
    logic waiting;
    logic dir;
    logic ack;
    logic start;
    logic stop;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic sda_o;
    logic sda_oe;
    logic irq;
  } ibsf_state_type;

  ibsf_state_type s_q;
  ibsf_state_type s_d;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // ==========================================================
  // pin synchronisers and condition detector
  ibsf_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({serial_clock_line, serial_data_line_in}),
    .sync_out({scl_s, sda_s})
  );

  ibsf_cond u_cond (
    .mclk(mclk),
    .rst(rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // ==========================================================
  // next state
  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic start_gen;
  logic wait_rel;
  logic comm_save;
  logic en_fall;
  logic ald_rise;
  logic start_ev;
  logic stop_ev;
  logic first_clk;
  logic dir_bit_clk;
  logic ack_clk;
  logic ack_fall;
  logic dir_set;
  logic dir_clr;
  logic [2:0] irq_set;
  logic [7:0] status;

  always_comb
  begin
    s_d = s_q;
    wr_ctrl = reg_wr && (reg_addr == ibsf_pkg::OFS_CTRL);
    wr_irq_en = reg_wr && (reg_addr == ibsf_pkg::OFS_IRQ_EN);
    wr_irq_clr = reg_wr && (reg_addr == ibsf_pkg::OFS_IRQ_CLR);
    start_gen = wr_ctrl && reg_wdata[ibsf_pkg::CT_START_GEN] && s_q.enable
      && s_q.master;
    wait_rel = wr_ctrl && reg_wdata[ibsf_pkg::CT_WAIT_REL];
    comm_save = wr_ctrl && reg_wdata[ibsf_pkg::CT_COMM_SAVE];
    en_fall = s_q.en_prev && !s_q.enable;
    ald_rise = arbitration_lost_flag && !s_q.ald_prev;
    start_ev = start_det && s_q.enable;
    stop_ev = stop_det && s_q.enable;
    first_clk = scl_rise && s_q.enable
      && ((s_q.cnt == ibsf_pkg::CNT_ACK_BIT)
      || (s_q.cnt == ibsf_pkg::CNT_IDLE));
    // cnt holds the rises already seen in this byte, so the
    // eighth rise arrives while cnt still reads one less
    dir_bit_clk = scl_rise && s_q.enable && s_q.first_byte
      && (s_q.cnt == (ibsf_pkg::CNT_DIR_BIT - 4'h1));
    ack_clk = scl_rise && s_q.enable
      && (s_q.cnt == ibsf_pkg::CNT_DIR_BIT);
    ack_fall = scl_fall && s_q.enable
      && (s_q.cnt == ibsf_pkg::CNT_ACK_BIT);

    s_d.en_prev = s_q.enable;
    s_d.ald_prev = arbitration_lost_flag;

    // ----------------------------------------------------------
    // control register
    if (wr_ctrl)
    begin
      s_d.enable = reg_wdata[ibsf_pkg::CT_ENABLE];
      s_d.master = reg_wdata[ibsf_pkg::CT_MASTER];
    end

    // ----------------------------------------------------------
    // serial clock counter and byte phase
    if (start_ev || stop_ev || !s_q.enable)
    begin
      s_d.cnt = ibsf_pkg::CNT_IDLE;
      s_d.first_byte = start_ev;
      s_d.phase = start_ev ? ibsf_pkg::IBSF_PH_ADDR
        : ibsf_pkg::IBSF_PH_IDLE;
    end
    else if (scl_rise)
    begin
      if (s_q.cnt == ibsf_pkg::CNT_ACK_BIT)
      begin
        s_d.cnt = ibsf_pkg::CNT_FIRST;
        s_d.first_byte = 1'b0;
        if (s_q.phase == ibsf_pkg::IBSF_PH_ADDR)
          s_d.phase = ibsf_pkg::IBSF_PH_DATA;
      end
      else
        s_d.cnt = s_q.cnt + 4'h1;
    end

    // bus held low after ninth clock until released
    if (ack_fall)
      s_d.waiting = 1'b1;
    else if (scl_rise || start_ev || stop_ev || wait_rel || !s_q.enable)
      s_d.waiting = 1'b0;

    // ----------------------------------------------------------
    // direction flag
    dir_set = 1'b0;
    dir_clr = 1'b0;
    if (start_gen)
      dir_set = 1'b1; // R3
    if (dir_bit_clk && !s_q.master && sda_s)
      dir_set = 1'b1; // R4
    if (dir_bit_clk && s_q.master && s_q.dir && shift_out_bit)
      dir_clr = 1'b1; // R5
    if (stop_ev || comm_save || en_fall || ald_rise)
      dir_clr = 1'b1; // R6
    if (start_ev && !s_q.master)
      dir_clr = 1'b1; // R6
    if (wait_rel && s_q.dir && s_q.waiting)
      dir_clr = 1'b1; // R7
    if (dir_clr)
      s_d.dir = 1'b0;
    else if (dir_set)
      s_d.dir = 1'b1;

    // drive window opens at master start generation or first byte ninth clock fall
    if (dir_clr || !s_q.enable)
      s_d.drive_ok = 1'b0; // R7
    else if (start_gen)
      s_d.drive_ok = 1'b1;
    else if (ack_fall && s_q.first_byte)
      s_d.drive_ok = 1'b1; // R2

    // ----------------------------------------------------------
    // acknowledge flag
    if (ack_clk && !sda_s)
      s_d.ack = 1'b1; // R8
    else if (stop_ev || first_clk || comm_save || en_fall)
      s_d.ack = 1'b0; // R9

    // ----------------------------------------------------------
    // start and stop flags
    if (start_ev)
      s_d.start = 1'b1; // R10
    else if (stop_ev || comm_save || en_fall)
      s_d.start = 1'b0; // R11
    else if (first_clk && s_q.phase == ibsf_pkg::IBSF_PH_ADDR
      && s_q.cnt == ibsf_pkg::CNT_ACK_BIT)
      s_d.start = 1'b0; // R11

    if (stop_ev)
      s_d.stop = 1'b1; // R12
    else if (en_fall || !s_q.enable)
      s_d.stop = 1'b0; // R13
    else if (scl_rise && s_q.start && s_q.cnt == ibsf_pkg::CNT_IDLE)
      s_d.stop = 1'b0; // R13

    // ----------------------------------------------------------
    // interrupts, set wins over clear
    irq_set = '0;
    irq_set[ibsf_pkg::IQ_START] = start_ev;
    irq_set[ibsf_pkg::IQ_STOP] = stop_ev;
    irq_set[ibsf_pkg::IQ_ACK] = ack_clk && !sda_s;
    if (wr_irq_en)
      s_d.irq_en = reg_wdata[2:0];
    if (wr_irq_clr)
      s_d.irq_stat = (s_q.irq_stat & ~reg_wdata[2:0]) | irq_set;
    else
      s_d.irq_stat = s_q.irq_stat | irq_set;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);

    // ----------------------------------------------------------
    // data line: released unless transmitting
    s_d.sda_oe = s_d.dir && s_d.drive_ok; // R1 R2
    s_d.sda_o = s_d.sda_oe ? shift_out_bit : 1'b1;

    // ----------------------------------------------------------
    // register read, status is never written
    status = ibsf_pkg::STATUS_RST; // R14 R15
    status[ibsf_pkg::ST_DIR] = s_q.dir;
    status[ibsf_pkg::ST_ACK] = s_q.ack;
    status[ibsf_pkg::ST_START] = s_q.start;
    status[ibsf_pkg::ST_STOP] = s_q.stop;
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == ibsf_pkg::OFS_STATUS)
        s_d.rdata = status; // R14
      else if (reg_addr == ibsf_pkg::OFS_CTRL)
        s_d.rdata = {6'h00, s_q.master, s_q.enable};
      else if (reg_addr == ibsf_pkg::OFS_IRQ_STAT)
        s_d.rdata = {5'h00, s_q.irq_stat};
      else if (reg_addr == ibsf_pkg::OFS_IRQ_EN)
        s_d.rdata = {5'h00, s_q.irq_en};
      else
        s_d.rdata = 8'h00;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q <= '0; // R14
      s_q.phase <= ibsf_pkg::IBSF_PH_IDLE;
      s_q.enable <= ibsf_pkg::CTRL_RST[0];
      s_q.master <= ibsf_pkg::CTRL_RST[1];
      s_q.irq_stat <= ibsf_pkg::IRQ_RST;
      s_q.irq_en <= ibsf_pkg::IRQ_RST;
      s_q.sda_o <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  assign reg_rdata = s_q.rdata;
  assign serial_data_line_out = s_q.sda_o;
  assign serial_data_line_oe = s_q.sda_oe;
  assign transfer_direction_flag = s_q.dir;
  assign ack_seen_flag = s_q.ack;
  assign start_seen_flag = s_q.start;
  assign stop_seen_flag = s_q.stop;
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// ### ibsf_top_assertions.sv
// port level checks for the bus status flag block
// assumes a bind into ibsf_top and the single mclk domain
`timescale 1ns/1ps
`default_nettype none
module ibsf_top_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // serial lines
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  // neighbouring logic
  input wire logic arbitration_lost_flag,
  input wire logic shift_out_bit,
  // flags and interrupt
  input wire logic transfer_direction_flag,
  input wire logic ack_seen_flag,
  input wire logic start_seen_flag,
  input wire logic stop_seen_flag,
  input wire logic irq
);
  logic [3:0] flags;
  assign flags = {transfer_direction_flag, ack_seen_flag,
    start_seen_flag, stop_seen_flag};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // direction and data line
  a_dir_release: assert property (
    !transfer_direction_flag && !$past(transfer_direction_flag)
    |-> !serial_data_line_oe)
    else $error("data line driven while receiving");
  a_drive_value: assert property (
    serial_data_line_oe |-> serial_data_line_out == $past(shift_out_bit))
    else $error("driven value is not the shift bit");
  a_arb_clear: assert property (
    $rose(arbitration_lost_flag) |-> ##[1:2] !transfer_direction_flag)
    else $error("direction kept after arbitration loss");
  // ==========================================
  // line events
  a_ack_cause: assert property (
    $rose(ack_seen_flag)
    |-> $past(serial_clock_line, 2) && !$past(serial_data_line_in, 2))
    else $error("ack flag without low data at clock high");
  a_start_cause: assert property (
    $rose(start_seen_flag)
    |-> $past(serial_clock_line, 2) && !$past(serial_data_line_in, 2))
    else $error("start flag without start condition");
  a_stop_cause: assert property (
    $rose(stop_seen_flag)
    |-> $past(serial_clock_line, 2) && $past(serial_data_line_in, 2))
    else $error("stop flag without stop condition");
  a_stop_clears: assert property (
    $rose(stop_seen_flag)
    |-> !ack_seen_flag && !start_seen_flag && !transfer_direction_flag)
    else $error("flags left set at stop");
  a_stop_hold: assert property (
    $fell(stop_seen_flag) |-> $past(serial_clock_line))
    else $error("stop flag dropped with clock low");
  // ==========================================
  // register view
  a_status_read: assert property (
    $past(reg_rd) && $past(reg_addr) == ibsf_pkg::OFS_STATUS
    |-> reg_rdata == {4'h0, $past(flags)})
    else $error("status read differs from flags");
  c_dir: cover property ($rose(transfer_direction_flag));
  c_irq: cover property ($rose(irq));
  c_restart: cover property (stop_seen_flag && $rose(start_seen_flag));
endmodule
bind ibsf_top ibsf_top_assertions i_chk (
  .mclk, .rst, .reg_addr, .reg_rd, .reg_rdata, .serial_clock_line,
  .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe,
  .arbitration_lost_flag, .shift_out_bit, .transfer_direction_flag,
  .ack_seen_flag, .start_seen_flag, .stop_seen_flag, .irq);
`default_nettype wire

// ### ibsf_peer.sv
// remote master on the two wire bus, 125 ns clock in frames
// assumes the bench joins the data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ibsf_peer (
  // lines, 1 means released
  output var logic scl,
  output var logic sda_o
);
  initial
  begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // ==========================================
  // quarter period steps
  task automatic ph(input logic c, input logic s);
    scl = c;
    #31.25;
    sda_o = s;
    #31.25;
  endtask
  task automatic start_c;
    ph(1'b1, 1'b0);
  endtask
  task automatic stop_c;
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // eight bits msb first, then the ack slot
  task automatic put(input logic [7:0] b, input logic ack_n);
    for (int i = 7; i >= 0; i--)
    begin
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
    end
    ph(1'b0, ack_n);
    ph(1'b1, ack_n);
    ph(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### tb_ibsf_top.sv
// bench for the bus status flag block
// assumes the peer model on the lines, register port on mclk
`timescale 1ns/1ps
`default_nettype none
module tb_ibsf_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl;
  logic sda_m;
  logic sda_w;
  logic arbitration_lost_flag = 1'b0;
  logic shift_out_bit = 1'b0;
  logic serial_data_line_out;
  logic serial_data_line_oe;
  logic irq;
  logic dir_f;
  logic ack_f;
  logic start_f;
  logic stop_f;
  int err_count = 0;
  int num_checks = 0;
  always #2 mclk = ~mclk;
  // pulled up wire
  assign sda_w = sda_m & ~(serial_data_line_oe & ~serial_data_line_out);
  ibsf_peer i_ibsf_peer (.scl(scl), .sda_o(sda_m));
  ibsf_top i_ibsf_top (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_clock_line(scl), .serial_data_line_in(sda_w),
    .serial_data_line_out, .serial_data_line_oe,
    .arbitration_lost_flag, .shift_out_bit,
    .transfer_direction_flag(dir_f), .ack_seen_flag(ack_f),
    .start_seen_flag(start_f), .stop_seen_flag(stop_f), .irq);
  // ==========================================
  // tasks
  task automatic close_out;
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %0t got %h want %h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, e);
  endtask
  // settle after line activity, then read status
  task automatic st(input logic [7:0] e);
    repeat (8) @(posedge mclk);
    rd(ibsf_pkg::OFS_STATUS, e);
    cmp({4'h0, dir_f, ack_f, start_f, stop_f}, e);
  endtask
  task automatic ck_irq(input logic e);
    repeat (3) @(posedge mclk);
    #1;
    cmp({7'h00, irq}, {7'h00, e});
  endtask
  // ==========================================
  // sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    st(8'h00);
    rd(4'hF, 8'h00);
    wr(ibsf_pkg::OFS_IRQ_EN, 8'h07);
    wr(ibsf_pkg::OFS_CTRL, 8'h01);
    i_ibsf_peer.start_c();
    st(8'h02);
    i_ibsf_peer.put(8'hA1, 1'b0);
    st(8'h0E);
    cmp({6'h00, serial_data_line_oe, serial_data_line_out}, 8'h02);
    cmp({7'h00, sda_w}, 8'h00);
    shift_out_bit <= 1'b1;
    wr(ibsf_pkg::OFS_CTRL, 8'h09);
    st(8'h06);
    cmp({7'h00, serial_data_line_oe}, 8'h00);
    wr(ibsf_pkg::OFS_STATUS, 8'hFF);
    st(8'h06);
    i_ibsf_peer.put(8'h55, 1'b1);
    st(8'h00);
    i_ibsf_peer.stop_c();
    st(8'h01);
    rd(ibsf_pkg::OFS_IRQ_STAT, 8'h07);
    ck_irq(1'b1);
    wr(ibsf_pkg::OFS_IRQ_EN, 8'h00);
    ck_irq(1'b0);
    wr(ibsf_pkg::OFS_IRQ_EN, 8'h07);
    ck_irq(1'b1);
    wr(ibsf_pkg::OFS_IRQ_CLR, 8'h07);
    ck_irq(1'b0);
    rd(ibsf_pkg::OFS_IRQ_STAT, 8'h00);
    i_ibsf_peer.start_c();
    st(8'h03);
    i_ibsf_peer.put(8'h10, 1'b0);
    st(8'h06);
    wr(ibsf_pkg::OFS_CTRL, 8'h11);
    st(8'h00);
    i_ibsf_peer.stop_c();
    wr(ibsf_pkg::OFS_CTRL, 8'h00);
    st(8'h00);
    wr(ibsf_pkg::OFS_CTRL, 8'h03);
    wr(ibsf_pkg::OFS_CTRL, 8'h07);
    st(8'h08);
    arbitration_lost_flag <= 1'b1;
    @(posedge mclk);
    arbitration_lost_flag <= 1'b0;
    st(8'h00);
    wr(ibsf_pkg::OFS_CTRL, 8'h07);
    i_ibsf_peer.start_c();
    st(8'h0A);
    i_ibsf_peer.put(8'h01, 1'b0);
    st(8'h06);
    i_ibsf_peer.stop_c();
    st(8'h01);
    close_out();
  end
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
